// ==== rtl/ccg_halt_detect.sv ====
`timescale 1ns/1ns
module ccg_halt_detect (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // External oscillator activity
    input  wire logic ext_tick_i,
    // Result
    output logic      halted_o
);

    // ------------------------------------------------------------
    // Silence counter
    // ------------------------------------------------------------
    logic [7:0] quiet_r;

    // Saturates, so a long stop never wraps back to running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quiet_r <= 8'h00;
        end else if (ext_tick_i) begin
            quiet_r <= 8'h00;
        end else if (quiet_r != 8'(ccg_pkg::HALT_CYCLES)) begin
            quiet_r <= quiet_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halted_o <= 1'b0;
        end else begin
            halted_o <= !ext_tick_i && (quiet_r == 8'(ccg_pkg::HALT_CYCLES));
        end
    end

endmodule : ccg_halt_detect

// ==== rtl/ccg_pkg.sv ====
package ccg_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] RC_CTRL_OFS   = 8'h00;
    localparam logic [7:0] CLK_CTRL_OFS  = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RC_STANDBY_BIT    = 7;
    localparam int RC_FREQ_SEL_BIT   = 6;
    localparam int RC_SUPPLY_SEL_BIT = 5;
    localparam int RC_DIV_HI_BIT     = 1;
    localparam int RC_DIV_LO_BIT     = 0;
    localparam int EXT_SELECT_BIT    = 0;
    localparam int SRC_STATUS_BIT    = 1;
    localparam int HALT_SEEN_BIT     = 2;
    localparam int IRQ_SWITCH_BIT    = 0;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] RC_CTRL_RST   = 8'h00;
    localparam logic [7:0] RC_CTRL_RMASK = 8'he3;
    localparam logic [1:0] DIV_BY_2      = 2'h2;
    localparam logic [1:0] DIV_BY_4      = 2'h3;
    localparam logic [1:0] DIV_CNT_RST   = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int HALT_TIME_NS  = 2000;
    localparam int HALT_CYCLES   = (HALT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRESC_WIDTH   = 13;

    typedef enum logic [1:0] {
        SRC_RC     = 2'b00,
        SRC_EXT    = 2'b01,
        SRC_TO_EXT = 2'b10,
        SRC_TO_RC  = 2'b11
    } ccg_src_t;

endpackage : ccg_pkg

// ==== rtl/ccg_prescaler.sv ====
`timescale 1ns/1ns
module ccg_prescaler (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // System clock enable
    input  wire logic                              sys_tick_i,
    // Divided ticks, bit k is phi divided by 2 to the k+1
    output logic [ccg_pkg::PRESC_WIDTH-1:0]        div_tick_o
);

    logic [ccg_pkg::PRESC_WIDTH-1:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (sys_tick_i) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // One tap per ratio, from /2 up to /8192
    // ------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < ccg_pkg::PRESC_WIDTH; k++) begin : g_tap
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    div_tick_o[k] <= 1'b0;
                end else begin
                    div_tick_o[k] <= sys_tick_i && (&cnt_r[k:0]);
                end
            end
        end
    endgenerate

endmodule : ccg_prescaler

// ==== rtl/ccg_top.sv ====
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Operation
// - Two system clock sources are offered, the internal RC oscillator and the external one.
// - The system clock feeds a prescaler giving phi/2 down to phi/8192 to peripherals.
// - When the external oscillator stops, the system clock moves to the RC clock by itself.
// - A move from external to RC clock can raise an interrupt to the CPU.
// - Bit 7 of the RC control register set to 1 puts the RC oscillator in standby; resets 0.
// - Bit 6 picks the RC frequency, 0 for 8 MHz and 1 for 10 MHz; resets 0.
// - Bit 5 powers the RC from the bandgap when 0 and the regulated supply when 1.
// - Bits 4 to 2 of the RC control register always read 0.
// - Division field bits 1..0 pass the RC clock when 0x, halve it at 10, quarter it at 11.
// - A new division ratio acts at once after the write.
// - Division writes are taken only while the clock source status reads 0.
module ccg_top (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // Wishbone slave
    input  wire logic [7:0]                        wb_adr_i,
    input  wire logic [31:0]                       wb_dat_i,
    input  wire logic [3:0]                        wb_sel_i,
    input  wire logic                              wb_we_i,
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    output logic [31:0]                            wb_dat_o,
    output logic                                   wb_ack_o,
    // Oscillator ticks
    input  wire logic                              ext_osc_tick_i,
    input  wire logic                              rc_osc_tick_i,
    // RC oscillator controls
    output logic                                   rc_standby_o,
    output logic                                   rc_freq_select_o,
    output logic                                   rc_supply_select_o,
    // Clock outputs
    output logic                                   sys_tick_o,
    output logic [ccg_pkg::PRESC_WIDTH-1:0]        presc_tick_o,
    output logic                                   clock_source_status_o,
    // Interrupt
    output logic                                   irq_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]       rc_control_reg_r;
    logic             ext_select_r;
    logic             halt_seen_r;
    logic             irq_stat_r;
    logic             irq_mask_r;
    logic [1:0]       rc_div_cnt_r;
    logic             rc_div_tick;
    logic             halted;
    logic             switch_evt;
    logic             wr_en;
    logic             wr_rc;
    logic             wr_div_ok;
    logic [31:0]      rd_data;
    ccg_pkg::ccg_src_t src_r;
    ccg_pkg::ccg_src_t src_nxt;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr == ofs);
    endfunction : hit

    // Write acts on the ack edge only, so one bus cycle writes once
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign wr_rc = wr_en && hit(wb_adr_i, ccg_pkg::RC_CTRL_OFS);
    assign wr_div_ok = wr_rc && !clock_source_status_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit(wb_adr_i, ccg_pkg::RC_CTRL_OFS)) begin
            rd_data[7:0] = rc_control_reg_r & ccg_pkg::RC_CTRL_RMASK;
        end else if (hit(wb_adr_i, ccg_pkg::CLK_CTRL_OFS)) begin
            rd_data[ccg_pkg::EXT_SELECT_BIT] = ext_select_r;
            rd_data[ccg_pkg::SRC_STATUS_BIT] = clock_source_status_o;
            rd_data[ccg_pkg::HALT_SEEN_BIT]  = halt_seen_r;
        end else if (hit(wb_adr_i, ccg_pkg::IRQ_STAT_OFS)) begin
            rd_data[ccg_pkg::IRQ_SWITCH_BIT] = irq_stat_r;
        end else if (hit(wb_adr_i, ccg_pkg::IRQ_MASK_OFS)) begin
            rd_data[ccg_pkg::IRQ_SWITCH_BIT] = irq_mask_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= rd_data;
        end
    end

    // ------------------------------------------------------------
    // RC control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_control_reg_r <= ccg_pkg::RC_CTRL_RST;
        end else if (wr_rc) begin
            rc_control_reg_r[ccg_pkg::RC_STANDBY_BIT] <=
                wb_dat_i[ccg_pkg::RC_STANDBY_BIT];
            rc_control_reg_r[ccg_pkg::RC_FREQ_SEL_BIT] <=
                wb_dat_i[ccg_pkg::RC_FREQ_SEL_BIT];
            rc_control_reg_r[ccg_pkg::RC_SUPPLY_SEL_BIT] <=
                wb_dat_i[ccg_pkg::RC_SUPPLY_SEL_BIT];
            if (wr_div_ok) begin
                rc_control_reg_r[ccg_pkg::RC_DIV_HI_BIT] <=
                    wb_dat_i[ccg_pkg::RC_DIV_HI_BIT];
                rc_control_reg_r[ccg_pkg::RC_DIV_LO_BIT] <=
                    wb_dat_i[ccg_pkg::RC_DIV_LO_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_standby_o       <= 1'b0;
            rc_freq_select_o   <= 1'b0;
            rc_supply_select_o <= 1'b0;
        end else begin
            rc_standby_o       <= rc_control_reg_r[ccg_pkg::RC_STANDBY_BIT];
            rc_freq_select_o   <= rc_control_reg_r[ccg_pkg::RC_FREQ_SEL_BIT];
            // Regulated supply trades frequency accuracy for power
            rc_supply_select_o <= rc_control_reg_r[ccg_pkg::RC_SUPPLY_SEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Clock control register
    // ------------------------------------------------------------
    // A halt clears the external request; hardware beats software here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_select_r <= 1'b0;
        end else if (halted) begin
            ext_select_r <= 1'b0;
        end else if (wr_en && hit(wb_adr_i, ccg_pkg::CLK_CTRL_OFS)) begin
            ext_select_r <= wb_dat_i[ccg_pkg::EXT_SELECT_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_seen_r <= 1'b0;
        end else begin
            halt_seen_r <= halted;
        end
    end

    // ------------------------------------------------------------
    // RC divider
    // ------------------------------------------------------------
    // Counter restarts on a ratio write so the new ratio acts at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_div_cnt_r <= ccg_pkg::DIV_CNT_RST;
        end else if (wr_div_ok) begin
            rc_div_cnt_r <= ccg_pkg::DIV_CNT_RST;
        end else if (rc_osc_tick_i) begin
            rc_div_cnt_r <= rc_div_cnt_r + 2'h1;
        end
    end

    always_comb begin
        rc_div_tick = 1'b0;
        case (rc_control_reg_r[ccg_pkg::RC_DIV_HI_BIT:ccg_pkg::RC_DIV_LO_BIT])
            ccg_pkg::DIV_BY_2: rc_div_tick = rc_osc_tick_i && rc_div_cnt_r[0];
            ccg_pkg::DIV_BY_4: rc_div_tick = rc_osc_tick_i && (&rc_div_cnt_r);
            default:           rc_div_tick = rc_osc_tick_i;
        endcase
    end

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    // Hand-over waits for a whole tick of the new source, never a partial one
    always_comb begin
        src_nxt = src_r;
        case (src_r)
            ccg_pkg::SRC_RC: begin
                if (ext_select_r && !halted) begin
                    src_nxt = ccg_pkg::SRC_TO_EXT;
                end
            end
            ccg_pkg::SRC_TO_EXT: begin
                if (halted || !ext_select_r) begin
                    src_nxt = ccg_pkg::SRC_RC;
                end else if (ext_osc_tick_i) begin
                    src_nxt = ccg_pkg::SRC_EXT;
                end
            end
            ccg_pkg::SRC_EXT: begin
                if (halted || !ext_select_r) begin
                    src_nxt = ccg_pkg::SRC_TO_RC;
                end
            end
            ccg_pkg::SRC_TO_RC: begin
                if (rc_div_tick) begin
                    src_nxt = ccg_pkg::SRC_RC;
                end
            end
            default: src_nxt = ccg_pkg::SRC_RC;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_r <= ccg_pkg::SRC_RC;
        end else begin
            src_r <= src_nxt;
        end
    end

    assign switch_evt = (src_r == ccg_pkg::SRC_TO_RC) && rc_div_tick;

    // Status reads 1 whenever the external clock drives or is being left
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_source_status_o <= 1'b0;
        end else begin
            clock_source_status_o <= (src_nxt == ccg_pkg::SRC_EXT) ||
                                     (src_nxt == ccg_pkg::SRC_TO_RC);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_tick_o <= 1'b0;
        end else begin
            case (src_r)
                ccg_pkg::SRC_EXT:    sys_tick_o <= ext_osc_tick_i;
                ccg_pkg::SRC_TO_EXT: sys_tick_o <= ext_osc_tick_i ? 1'b0 : rc_div_tick;
                ccg_pkg::SRC_TO_RC:  sys_tick_o <= rc_div_tick;
                default:             sys_tick_o <= rc_div_tick;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= 1'b0;
        end else if (switch_evt) begin
            irq_stat_r <= 1'b1;
        end else if (wr_en && hit(wb_adr_i, ccg_pkg::IRQ_STAT_OFS) &&
                     wb_dat_i[ccg_pkg::IRQ_SWITCH_BIT]) begin
            irq_stat_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= 1'b0;
        end else if (wr_en && hit(wb_adr_i, ccg_pkg::IRQ_MASK_OFS)) begin
            irq_mask_r <= wb_dat_i[ccg_pkg::IRQ_SWITCH_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_stat_r && irq_mask_r;
        end
    end

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    ccg_halt_detect u_halt (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ext_tick_i (ext_osc_tick_i),
        .halted_o   (halted)
    );

    ccg_prescaler u_presc (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .sys_tick_i (sys_tick_o),
        .div_tick_o (presc_tick_o)
    );

endmodule : ccg_top

// ==== test/ccg_osc_model.sv ====
`timescale 1ns/1ns
module ccg_osc_model #(
    parameter int EXT_PERIOD = 3
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Controls
    input  wire logic ext_run_i,
    input  wire logic rc_standby_i,
    input  wire logic rc_freq_select_i,
    // Ticks
    output logic      ext_tick_o,
    output logic      rc_tick_o
);
    logic [3:0] rc_cnt_r;
    logic [3:0] ext_cnt_r;

    // Coarse periods: 5 cycles for the slow setting, 4 for the fast one
    always_ff @(posedge clk_i) begin
        if (rst_i || rc_standby_i) begin
            rc_cnt_r  <= 4'h0;
            rc_tick_o <= 1'b0;
        end else begin
            rc_tick_o <= (rc_cnt_r == 4'h0);
            rc_cnt_r  <= (rc_cnt_r != 4'h0) ? rc_cnt_r - 4'h1 :
                         (rc_freq_select_i ? 4'h3 : 4'h4);
        end
    end

    // A stopped crystal gives no ticks at all
    always_ff @(posedge clk_i) begin
        if (rst_i || !ext_run_i) begin
            ext_cnt_r  <= 4'h0;
            ext_tick_o <= 1'b0;
        end else begin
            ext_tick_o <= (ext_cnt_r == 4'h0);
            ext_cnt_r  <= (ext_cnt_r != 4'h0) ? ext_cnt_r - 4'h1 : 4'(EXT_PERIOD - 1);
        end
    end
endmodule : ccg_osc_model

// ==== test/ccg_top_asserts.sv ====
`timescale 1ns/1ns
module ccg_top_asserts (
    // Clock and reset
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    // Register bus
    input wire logic [7:0]                  wb_adr_i,
    input wire logic [31:0]                 wb_dat_i,
    input wire logic [3:0]                  wb_sel_i,
    input wire logic                        wb_we_i,
    input wire logic                        wb_cyc_i,
    input wire logic                        wb_stb_i,
    input wire logic [31:0]                 wb_dat_o,
    input wire logic                        wb_ack_o,
    // Clocks and controls
    input wire logic                        ext_osc_tick_i,
    input wire logic                        rc_osc_tick_i,
    input wire logic                        rc_standby_o,
    input wire logic                        rc_freq_select_o,
    input wire logic                        rc_supply_select_o,
    input wire logic                        sys_tick_o,
    input wire logic [ccg_pkg::PRESC_WIDTH-1:0] presc_tick_o,
    input wire logic                        clock_source_status_o,
    input wire logic                        irq_o
);
    logic [7:0] gap_r;
    logic [7:0] wd_r;

    // Cycles since the last external tick, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i || ext_osc_tick_i) begin
            gap_r <= 8'h00;
        end else if (gap_r != 8'hff) begin
            gap_r <= gap_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wb_ack_o && wb_we_i) begin
            wd_r <= wb_dat_i[7:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rc_wr;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ccg_pkg::RC_CTRL_OFS;
    endsequence
    sequence s_rd;
        wb_ack_o && !wb_we_i;
    endsequence

    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_CTRL_OUT: assert property (s_rc_wr |=> ##[0:1] (rc_standby_o == wd_r[7]
        && rc_freq_select_o == wd_r[6] && rc_supply_select_o == wd_r[5]))
        else $error("rc control outputs do not follow write");
    AST_RSV_ZERO: assert property (s_rd ##0 wb_adr_i == 8'h00 |->
        (wb_dat_o & 32'hffffff1c) == 32'h0)
        else $error("reserved rc control bits read nonzero");
    AST_UNMAPPED: assert property (s_rd ##0 (wb_adr_i[1:0] != 2'h0 || wb_adr_i > 8'h0c)
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_SYS_CAUSE: assert property (sys_tick_o |-> $past(rc_osc_tick_i || ext_osc_tick_i))
        else $error("system tick without source tick");
    AST_PRESC_CAUSE: assert property (presc_tick_o != '0 |-> $past(sys_tick_o))
        else $error("prescaler tick without system tick");
    AST_HALT_SWITCH: assert property (gap_r == 8'd150 && !rc_standby_o
        |-> !clock_source_status_o)
        else $error("no switch to rc after external halt");
    AST_IRQ_SRC: assert property ($rose(irq_o) |-> !clock_source_status_o)
        else $error("interrupt while external source active");
endmodule : ccg_top_asserts

bind ccg_top ccg_top_asserts i_ccg_top_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_osc_tick_i(ext_osc_tick_i),
    .rc_osc_tick_i(rc_osc_tick_i), .rc_standby_o(rc_standby_o),
    .rc_freq_select_o(rc_freq_select_o), .rc_supply_select_o(rc_supply_select_o),
    .sys_tick_o(sys_tick_o), .presc_tick_o(presc_tick_o),
    .clock_source_status_o(clock_source_status_o), .irq_o(irq_o));

// ==== test/ccg_top_bench.sv ====
`timescale 1ns/1ns
module ccg_top_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h0;
    logic        we    = 1'b0;
    logic        cyc   = 1'b0;
    logic        ext_run = 1'b0;
    logic [31:0] dat_o;
    logic        ack, ext_t, rc_t, stby, rc_freq_select, vsel, sys, stat, irq;
    logic [ccg_pkg::PRESC_WIDTH-1:0] presc;
    int          miscompares = 0;
    int          n_checks = 0;
    int          n_sys, n_rc, n_ext, n_p0;

    always #25 clk_i = ~clk_i;

    ccg_top i_ccg_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .ext_osc_tick_i(ext_t), .rc_osc_tick_i(rc_t), .rc_standby_o(stby),
        .rc_freq_select_o(rc_freq_select), .rc_supply_select_o(vsel), .sys_tick_o(sys),
        .presc_tick_o(presc), .clock_source_status_o(stat), .irq_o(irq));
    ccg_osc_model i_ccg_osc_model (.clk_i(clk_i), .rst_i(rst_i), .ext_run_i(ext_run),
        .rc_standby_i(stby), .rc_freq_select_i(rc_freq_select), .ext_tick_o(ext_t), .rc_tick_o(rc_t));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] f_rc(input logic [7:0] d);
        return {24'h0, d & 8'he3};
    endfunction : f_rc

    function automatic int f_div(input logic [1:0] c);
        return c[1] ? (c[0] ? 4 : 2) : 1;
    endfunction : f_div

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // Classic single cycle; a wait ends on the slave's ack or after 50 cycles
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk_i);
        adr <= a;
        we  <= w;
        dat <= d;
        cyc <= 1'b1;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        q = dat_o;
        cyc <= 1'b0;
        we  <= 1'b0;
        chk("bus ack", 1'b1, ack);
    endtask : wb

    task automatic win(input int n);
        n_sys = 0;
        n_rc  = 0;
        n_ext = 0;
        n_p0  = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            n_sys += sys;
            n_rc  += rc_t;
            n_ext += ext_t;
            n_p0  += presc[0];
        end
    endtask : win

    task automatic wait_stat(input logic v);
        int t;
        t = 0;
        while (stat !== v && t < 400) begin
            @(negedge clk_i);
            t++;
        end
        chk("source status", v, stat);
    endtask : wait_stat

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #(50 * 20000);
        miscompares++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        logic [31:0] q;
        logic [7:0]  r;
        int          e;
        void'($urandom(7689));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 24; a += 4) begin
            wb(8'(a), 1'b0, 32'h0, q);
            chk("reset value", 32'h0, q);
        end
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            r = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : 8'($urandom));
            wb(ccg_pkg::RC_CTRL_OFS, 1'b1, {24'h0, r}, q);
            wb(ccg_pkg::RC_CTRL_OFS, 1'b0, 32'h0, q);
            chk("rc control read", f_rc(r), q);
            chk("rc control pins", r[7:5], {stby, rc_freq_select, vsel});
        end
        $display("test rc control done");
        ext_run <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            r = {1'b0, 1'(c), 4'h0, 2'(c)};
            wb(ccg_pkg::RC_CTRL_OFS, 1'b1, {24'h0, r}, q);
            win(400);
            e = n_rc - n_sys * f_div(2'(c));
            chk("rc divide ratio", 1, e <= f_div(2'(c)) && e >= -f_div(2'(c)));
            e = n_sys - 2 * n_p0;
            chk("prescaler half", 1, e <= 2 && e >= -2);
        end
        $display("test rc divide done");
        wb(ccg_pkg::CLK_CTRL_OFS, 1'b1, 32'h1, q);
        wait_stat(1'b1);
        wb(ccg_pkg::CLK_CTRL_OFS, 1'b0, 32'h0, q);
        chk("clock control", 32'h3, q);
        wb(ccg_pkg::RC_CTRL_OFS, 1'b1, 32'h20, q);
        wb(ccg_pkg::RC_CTRL_OFS, 1'b0, 32'h0, q);
        chk("divide write blocked", 32'h23, q);
        win(300);
        e = n_ext - n_sys;
        chk("external drives system", 1, e <= 1 && e >= -1);
        $display("test external source done");
        wb(ccg_pkg::IRQ_MASK_OFS, 1'b1, 32'h1, q);
        ext_run <= 1'b0;
        wait_stat(1'b0);
        win(3);
        chk("irq after halt", 1'b1, irq);
        wb(ccg_pkg::CLK_CTRL_OFS, 1'b0, 32'h0, q);
        chk("halt seen", 32'h4, q);
        wb(ccg_pkg::IRQ_STAT_OFS, 1'b0, 32'h0, q);
        chk("irq status", 32'h1, q);
        for (int k = 0; k < 3; k++) begin
            wb((k == 2) ? ccg_pkg::IRQ_STAT_OFS : ccg_pkg::IRQ_MASK_OFS, 1'b1, 32'(k != 0), q);
            win(3);
            chk("irq level", k == 1, irq);
        end
        wb(ccg_pkg::CLK_CTRL_OFS, 1'b1, 32'h1, q);
        wb(ccg_pkg::CLK_CTRL_OFS, 1'b0, 32'h0, q);
        chk("select while halted", 32'h4, q);
        wb(ccg_pkg::RC_CTRL_OFS, 1'b1, 32'h02, q);
        wb(ccg_pkg::RC_CTRL_OFS, 1'b0, 32'h0, q);
        chk("divide write on rc", 32'h02, q);
        // Software deselect also ends in a switch to RC and raises the event
        ext_run <= 1'b1;
        win(3);
        wb(ccg_pkg::CLK_CTRL_OFS, 1'b1, 32'h1, q);
        wait_stat(1'b1);
        wb(ccg_pkg::CLK_CTRL_OFS, 1'b1, 32'h0, q);
        wait_stat(1'b0);
        win(3);
        chk("irq on deselect", 1'b1, irq);
        $display("test halt and interrupt done");
        end_of_test();
    end
endmodule : ccg_top_bench
